// >>> sixteen_bit_multimode_timer_tb.sv
// self-checking testbench for the multimode timer
`timescale 1ns/1ps
`include "timer_defines.vh"
module sixteen_bit_multimode_timer_tb;
    reg         clk_sys   = 1'b0;
    reg         rst_n     = 1'b0;
    reg  [3:0]  reg_addr  = 4'h0;
    reg  [15:0] reg_wdata = 16'h0000;
    reg         reg_write = 1'b0;
    reg         reg_read  = 1'b0;
    reg         in_cmd    = 1'b0;
    wire [15:0] reg_rdata;
    wire        timer_in;
    wire        timer_out;
    wire        timer_out_en;
    wire        irq_request;
    integer     bad_count = 0;
    integer     n_checks  = 0;
    integer     n;
    integer     p;
    reg  [15:0] rd;
    reg  [15:0] t0;
    reg         o1;
    // ============================================================
    // clock, design and pin source
    always #5 clk_sys = ~clk_sys;
    timer_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .timer_in(timer_in), .timer_out(timer_out),
        .timer_out_en(timer_out_en), .irq_request(irq_request));
    timer_pin_model pin_u (.clk_sys(clk_sys), .level_cmd(in_cmd), .timer_in(timer_in));
    // ============================================================
    // bus tasks; each starts just after a rising edge
    task wr(input [3:0] a, input [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task rd_reg(input [3:0] a);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(posedge clk_sys);
        rd = reg_rdata;
    endtask
    task check(input [127:0] what, input [15:0] seen, input [15:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    task rd_chk(input [3:0] a, input [15:0] exp, input [127:0] what);
        rd_reg(a);
        check(what, rd, exp);
    endtask
    // stop, configure, load count and reload, then enable
    task setup(input [15:0] cfg, input [15:0] cnt, input [15:0] rel);
        wr(`TMR_ADDR_CTRL, cfg);
        wr(`TMR_ADDR_COUNT, cnt);
        wr(`TMR_ADDR_RELOAD, rel);
        wr(`TMR_ADDR_CTRL, cfg | 16'h0001);
    endtask
    // cycles until a request pulse is seen, capped at lim
    task wait_irq(input integer lim, output integer cyc);
        cyc = 0;
        do begin
            @(posedge clk_sys);
            cyc = cyc + 1;
        end while (irq_request !== 1'b1 && cyc < lim);
    endtask
    // cycles for which the output stays at lvl
    task hold_len(input lvl, output integer cyc);
        cyc = 0;
        while (timer_out === lvl && cyc < 40) begin
            @(posedge clk_sys);
            cyc = cyc + 1;
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ============================================================
    // watchdog
    initial begin
        #200000;
        bad_count = bad_count + 1;
        give_verdict;
    end
    // ============================================================
    // test sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd_chk(`TMR_ADDR_CTRL, `TMR_CTRL_RST, "ctrl");
        rd_chk(`TMR_ADDR_COUNT, `TMR_COUNT_RST, "count");
        rd_chk(`TMR_ADDR_RELOAD, `TMR_RELOAD_RST, "reload");
        rd_chk(`TMR_ADDR_PWM, 16'h0000, "pwm");
        rd_chk(`TMR_ADDR_CAPTURE, 16'h0000, "capture");
        rd_chk(4'hA, 16'h0000, "unmapped");
        wr(`TMR_ADDR_CTRL, 16'h0112);
        rd_chk(`TMR_ADDR_CTRL, 16'h0112, "ctrl back");
        rd_chk(`TMR_ADDR_STATUS, 16'h0002, "idle out");
        wr(`TMR_ADDR_COUNT, 16'h1234);
        wr(`TMR_ADDR_RELOAD, 16'h0005);
        repeat (10) @(posedge clk_sys);
        rd_chk(`TMR_ADDR_COUNT, 16'h1234, "held count");
        rd_chk(`TMR_ADDR_RELOAD, 16'h0005, "reload");
        $display("test registers done");
        in_cmd <= 1'b1;
        setup(16'h0102, 16'h0003, 16'h0005);
        wait_irq(100, n);
        o1 = timer_out;
        wait_irq(100, n);
        check("cont period", n[15:0], 16'h0005);
        check("cont toggle", {15'h0000, timer_out}, {15'h0000, ~o1});
        rd_chk(`TMR_ADDR_COUNT, 16'h0002, "restart");
        setup(16'h0142, 16'h0001, 16'h0003);
        wait_irq(200, n);
        wait_irq(200, n);
        check("prescaled", n[15:0], 16'h000C);
        $display("test continuous done");
        setup(16'h0100, 16'h0001, 16'h0004);
        wait_irq(100, n);
        repeat (3) @(posedge clk_sys);
        rd_reg(`TMR_ADDR_STATUS);
        check("oneshot en", rd & 16'h0004, 16'h0000);
        wait_irq(50, n);
        check("oneshot stop", n[15:0], 16'h0032);
        in_cmd <= 1'b0;
        setup(16'h010A, 16'hFFFE, 16'h0002);
        wait_irq(20, n);
        check("cmp time", n[15:0], 16'h0004);
        check("cmp out", {15'h0000, timer_out}, 16'h0001);
        rd_chk(`TMR_ADDR_COUNT, 16'h0003, "cmp count");
        $display("test oneshot compare done");
        for (p = 0; p < 2; p = p + 1) begin
            in_cmd <= p[0];
            setup(16'h000C | {11'h000, p[0], 4'h0}, 16'h0001, 16'hFFFF);
            repeat (8) @(posedge clk_sys);
            rd_chk(`TMR_ADDR_COUNT, 16'h0001, "gate idle");
            in_cmd <= ~p[0];
            repeat (20) @(posedge clk_sys);
            in_cmd <= p[0];
            wait_irq(10, n);
            check("gate irq", {15'h0000, irq_request}, 16'h0001);
            rd_reg(`TMR_ADDR_STATUS);
            check("gate level", {15'h0000, rd[0]}, {15'h0000, p[0]});
            rd_reg(`TMR_ADDR_COUNT);
            t0 = rd;
            check("gate ran", {15'h0000, t0 > 16'h0010}, 16'h0001);
            repeat (5) @(posedge clk_sys);
            rd_chk(`TMR_ADDR_COUNT, t0, "gate hold");
        end
        in_cmd <= 1'b1;
        setup(16'h010C, 16'h0001, 16'h0004);
        wait_irq(100, n);
        wait_irq(100, n);
        check("gate reload", n[15:0], 16'h0004);
        $display("test gated done");
        for (p = 0; p < 2; p = p + 1) begin
            in_cmd <= p[0];
            setup(16'h0104 | {11'h000, p[0], 4'h0}, 16'h0001, 16'h0002);
            in_cmd <= ~p[0];
            repeat (6) @(posedge clk_sys);
            in_cmd <= p[0];
            repeat (6) @(posedge clk_sys);
            rd_chk(`TMR_ADDR_COUNT, 16'h0002, "edge count");
            in_cmd <= ~p[0];
            wait_irq(10, n);
            check("edge reload", {15'h0000, irq_request}, 16'h0001);
            check("edge toggle", {15'h0000, timer_out}, {15'h0000, ~p[0]});
        end
        for (p = 0; p < 2; p = p + 1) begin
            in_cmd <= ~p[0];
            setup(16'h0008 | {11'h000, p[0], 4'h0}, 16'h0001, 16'hFFFF);
            in_cmd <= p[0];
            wait_irq(10, n);
            check("wrong edge", {15'h0000, irq_request}, 16'h0000);
            in_cmd <= ~p[0];
            wait_irq(10, n);
            check("cap irq", {15'h0000, irq_request}, 16'h0001);
            rd_reg(`TMR_ADDR_CAPTURE);
            check("cap value", rd, 16'h000F);
        end
        $display("test counter capture done");
        for (p = 0; p < 2; p = p + 1) begin
            wr(`TMR_ADDR_PWM, 16'h0004);
            setup(16'h0006 | {11'h000, p[0], 4'h0}, 16'h0001, 16'h0008);
            hold_len(p[0], n);
            hold_len(~p[0], n);
            check("pwm active", n[15:0], 16'h0005);
            hold_len(p[0], n);
            check("pwm rest", n[15:0], 16'h0003);
        end
        wr(`TMR_ADDR_CTRL, 16'h0000);
        $display("test pwm done");
        give_verdict;
    end
endmodule

// >>> timer_core.v
// sixteen-bit multimode timer with register port and timer pins
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`include "timer_defines.vh"
`timescale 1ns/1ps

// Operation
// - continuous: count to reload, request interrupt, restart at 0001H, keep counting
// - continuous: software start count affects only the first pass
// - continuous: output toggles at every reload when output function enabled
// - one-shot, continuous, compare always count prescaled system clock
// - one-shot lasts (reload-start+1) ticks; continuous period lasts reload ticks
// - continuous first timeout from other start equals one-shot duration
// - compare: match keeps counting, toggles enabled output, at (compare-start) ticks
// - compare: counter wraps FFFFH to 0000H and keeps counting
// - gated: count only while input at active level chosen by polarity
// - gated: interrupt when input leaves active level or on reload
// - gated: reload restarts at 0001H and toggles enabled output
// - gated: polarity 0 counts high, polarity 1 counts low
// - disabled timer drives output to polarity; enabled toggles enabled output at reload, at match in compare, except pwm
// - counter mode: toggle enabled output after reload; polarity picks counted input edge
// - pwm: idle at polarity, match drives inverse, reload drives polarity
// - capture: latch count on rising edge (pol 0) or falling (pol 1)
module timer_core (
    input  wire                        clk_sys,
    input  wire                        rst_n,
    input  wire [`TMR_ADDR_W-1:0]      reg_addr,
    input  wire [`TMR_DATA_W-1:0]      reg_wdata,
    input  wire                        reg_write,
    input  wire                        reg_read,
    output reg  [`TMR_DATA_W-1:0]      reg_rdata,
    input  wire                        timer_in,
    output reg                         timer_out,
    output wire                        timer_out_en,
    output reg                         irq_request
);

    // ============================================================
    // registers and state
    reg  [`TMR_CTRL_W-1:0] ctrl;
    reg  [`TMR_DATA_W-1:0] count;
    reg  [`TMR_DATA_W-1:0] reload;
    reg  [`TMR_DATA_W-1:0] pwm_value;
    reg  [`TMR_DATA_W-1:0] capture;
    reg                    in_meta;
    reg                    in_sync;
    reg                    in_prev;

    reg  [`TMR_DATA_W-1:0] next_count;
    reg                    next_out;
    reg                    next_irq;
    reg                    next_stop;
    reg                    next_capture;
    reg  [`TMR_DATA_W-1:0] next_rdata;

    wire                   enable;
    wire [`TMR_MODE_W-1:0] mode;
    wire                   polarity;
    wire                   tick;
    wire                   in_rise;
    wire                   in_fall;
    wire                   in_active;
    wire                   edge_sel;
    wire                   gate_leave;
    wire                   advance;
    wire                   at_reload;
    wire [`TMR_DATA_W-1:0] count_inc;
    wire                   wr_ctrl;
    wire                   wr_count;

    assign enable       = ctrl[`TMR_CTRL_EN];
    assign mode         = ctrl[`TMR_CTRL_MODE_HI:`TMR_CTRL_MODE_LO];
    assign polarity     = ctrl[`TMR_CTRL_POL];
    assign timer_out_en = ctrl[`TMR_CTRL_OUTEN];
    assign wr_ctrl      = reg_write && (reg_addr == `TMR_ADDR_CTRL);
    assign wr_count     = reg_write && (reg_addr == `TMR_ADDR_COUNT);

    // ============================================================
    // timer input pin: two-flop synchroniser then an edge stage
    // the edge stage resets low like an idle-low pin; a pin idling high shows one
    // false rise after reset, harmless because the timer resets disabled
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            in_meta <= 1'b0;
            in_sync <= 1'b0;
            in_prev <= 1'b0;
        end else begin
            in_meta <= timer_in;
            in_sync <= in_meta;
            in_prev <= in_sync;
        end
    end

    assign in_rise    = in_sync && !in_prev;
    assign in_fall    = !in_sync && in_prev;
    assign in_active  = in_sync ^ polarity;
    assign edge_sel   = polarity ? in_fall : in_rise;
    assign gate_leave = polarity ? in_rise : in_fall;

    // ============================================================
    // prescaler, cleared while stopped so a fresh start gets full periods
    // hazard: a divider left running would give a short first period and
    // spoil the one-shot and continuous timeout lengths
    timer_prescaler u_prescaler (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .run          (enable),
        .prescale_sel (ctrl[`TMR_CTRL_PRE_HI:`TMR_CTRL_PRE_LO]),
        .tick         (tick)
    );

    // ============================================================
    // count advance source by mode
    assign advance = !enable ? 1'b0 :
                     (mode == `TMR_MODE_COUNTER) ? edge_sel :
                     (mode == `TMR_MODE_GATED) ? (tick && in_active) :
                     tick;

    // reload fires on the advance that finds count equal to reload, so a pass
    // from 0001H takes reload ticks and a pass from start s takes reload-s+1
    assign at_reload = (count == reload);
    assign count_inc = count + `TMR_COUNT_STEP;              // wraps to 0000H

    // ============================================================
    // next count, output level, interrupt and stop decisions
    // compare mode never reloads, so the counter runs on through FFFFH;
    // the pwm level is forced both ways and does not wait for outen
    always @* begin
        next_count   = count;
        next_out     = timer_out;
        next_irq     = 1'b0;
        next_stop    = 1'b0;
        next_capture = 1'b0;
        if (!enable) begin
            next_out = polarity;
        end else begin
            case (mode)
                `TMR_MODE_COMPARE: begin
                    if (advance) begin
                        next_count = count_inc;
                        if (count_inc == reload) begin
                            next_irq = 1'b1;
                            if (timer_out_en) begin
                                next_out = !timer_out;
                            end
                        end
                    end
                end
                `TMR_MODE_PWM: begin
                    if (advance) begin
                        if (at_reload) begin
                            next_count = `TMR_COUNT_RESTART;
                            next_out   = polarity;
                            next_irq   = 1'b1;
                        end else begin
                            next_count = count_inc;
                            if (count_inc == pwm_value) begin
                                next_out = !polarity;
                            end
                        end
                    end
                end
                `TMR_MODE_ONESHOT,
                `TMR_MODE_CONT,
                `TMR_MODE_COUNTER,
                `TMR_MODE_CAPTURE,
                `TMR_MODE_GATED: begin
                    if (advance) begin
                        if (at_reload) begin
                            next_count = `TMR_COUNT_RESTART;
                            next_irq   = 1'b1;
                            if (timer_out_en) begin
                                next_out = !timer_out;
                            end
                            if (mode == `TMR_MODE_ONESHOT) begin
                                next_stop = 1'b1;
                            end
                        end else begin
                            next_count = count_inc;
                        end
                    end
                    if ((mode == `TMR_MODE_GATED) && gate_leave) begin
                        next_irq = 1'b1;
                    end
                    if ((mode == `TMR_MODE_CAPTURE) && edge_sel) begin
                        next_capture = 1'b1;
                        next_irq     = 1'b1;
                    end
                end
                default: begin
                    next_count = count;
                end
            endcase
        end
    end

    // ============================================================
    // control register; one-shot clears its own enable at timeout
    // a software write wins over the self-clear when both fall in one cycle
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `TMR_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= reg_wdata[`TMR_CTRL_W-1:0];
        end else if (next_stop) begin
            ctrl[`TMR_CTRL_EN] <= 1'b0;
        end
    end

    // ============================================================
    // count register; a software write replaces the running value
    // so a count written while running takes effect at once
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count <= `TMR_COUNT_RST;
        end else if (wr_count) begin
            count <= reg_wdata;
        end else begin
            count <= next_count;
        end
    end

    // ============================================================
    // reload, pwm and capture registers
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reload    <= `TMR_RELOAD_RST;
            pwm_value <= `TMR_WORD_ZERO;
            capture   <= `TMR_WORD_ZERO;
        end else begin
            if (reg_write && (reg_addr == `TMR_ADDR_RELOAD)) begin
                reload <= reg_wdata;
            end
            if (reg_write && (reg_addr == `TMR_ADDR_PWM)) begin
                pwm_value <= reg_wdata;
            end
            if (next_capture) begin
                capture <= count;
            end
        end
    end

    // ============================================================
    // timer output pin and interrupt request pulse
    // requests are one-cycle pulses; an outside controller must latch them
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timer_out   <= 1'b0;
            irq_request <= 1'b0;
        end else begin
            timer_out   <= next_out;
            irq_request <= next_irq;
        end
    end

    // ============================================================
    // read mux; unmapped addresses read zero
    // the status input bit is the synchronised level, two cycles behind the pin
    always @* begin
        next_rdata = `TMR_WORD_ZERO;
        case (reg_addr)
            `TMR_ADDR_CTRL: begin
                next_rdata[`TMR_CTRL_W-1:0] = ctrl;
            end
            `TMR_ADDR_COUNT: begin
                next_rdata = count;
            end
            `TMR_ADDR_RELOAD: begin
                next_rdata = reload;
            end
            `TMR_ADDR_PWM: begin
                next_rdata = pwm_value;
            end
            `TMR_ADDR_CAPTURE: begin
                next_rdata = capture;
            end
            `TMR_ADDR_STATUS: begin
                next_rdata[`TMR_STAT_IN]  = in_sync;
                next_rdata[`TMR_STAT_OUT] = timer_out;
                next_rdata[`TMR_STAT_EN]  = enable;
            end
            default: begin
                next_rdata = `TMR_WORD_ZERO;
            end
        endcase
    end

    // ============================================================
    // read data stands only in the cycle after the read strobe
    // zero outside the read slot lets several slaves share an or-tree
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `TMR_WORD_ZERO;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= `TMR_WORD_ZERO;
        end
    end

endmodule

// >>> timer_core_checker.sv
// port checker for the multimode timer, bound to timer_core
`timescale 1ns/1ps
`include "timer_defines.vh"
module timer_core_checker (
    input wire                   clk_sys,
    input wire                   rst_n,
    input wire [`TMR_ADDR_W-1:0] reg_addr,
    input wire [`TMR_DATA_W-1:0] reg_wdata,
    input wire                   reg_write,
    input wire                   reg_read,
    input wire [`TMR_DATA_W-1:0] reg_rdata,
    input wire                   timer_in,
    input wire                   timer_out,
    input wire                   timer_out_en,
    input wire                   irq_request
);
    logic sw_en;
    wire  ctl_wr = reg_write && (reg_addr == `TMR_ADDR_CTRL);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ============================================================
    // software view of the enable bit; hardware clears are not seen
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            sw_en <= 1'b0;
        else if (ctl_wr)
            sw_en <= reg_wdata[`TMR_CTRL_EN];
    end
    // ============================================================
    // properties
    property p_rdata_idle;
        !$past(reg_read) |-> reg_rdata == 16'h0000;
    endproperty
    property p_unmapped_read;
        reg_read && (reg_addr > `TMR_ADDR_STATUS) |=> reg_rdata == 16'h0000;
    endproperty
    property p_ctrl_upper;
        reg_read && (reg_addr == `TMR_ADDR_CTRL) |=> reg_rdata[15:9] == 7'h00;
    endproperty
    property p_ctrl_readback;
        ctl_wr && !reg_wdata[0] ##1 !reg_write ##1 reg_read && (reg_addr == `TMR_ADDR_CTRL)
        |=> reg_rdata[8:0] == $past(reg_wdata[8:0], 3);
    endproperty
    property p_outen_follow;
        ctl_wr |=> timer_out_en == $past(reg_wdata[`TMR_CTRL_OUTEN]);
    endproperty
    property p_idle_level;
        ctl_wr && !reg_wdata[0] ##1 !ctl_wr |=> timer_out == $past(reg_wdata[4], 2);
    endproperty
    property p_irq_enabled;
        irq_request |-> sw_en || $past(sw_en);
    endproperty
    property p_status_en;
        reg_read && (reg_addr == `TMR_ADDR_STATUS) && !sw_en |=> reg_rdata[2] == 1'b0;
    endproperty
    property p_status_out;
        reg_read && (reg_addr == `TMR_ADDR_STATUS) |=> reg_rdata[1] == $past(timer_out);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
    a_ctrl_upper: assert property (p_ctrl_upper) else $error("control upper bits not zero");
    a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback differs");
    a_outen_follow: assert property (p_outen_follow) else $error("output enable not following");
    a_idle_level: assert property (p_idle_level) else $error("idle output level wrong");
    a_irq_enabled: assert property (p_irq_enabled) else $error("request while disabled");
    a_status_en: assert property (p_status_en) else $error("status enable bit wrong");
    a_status_out: assert property (p_status_out) else $error("status output bit wrong");
    // main scenarios reached
    c_irq: cover property (irq_request);
    c_out_rise: cover property ($rose(timer_out));
    c_cap_read: cover property (reg_read && (reg_addr == `TMR_ADDR_CAPTURE));
endmodule

bind timer_core timer_core_checker chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .timer_in(timer_in), .timer_out(timer_out),
    .timer_out_en(timer_out_en), .irq_request(irq_request));

// >>> timer_defines.vh
// constants for the sixteen-bit multimode timer
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

// ============================================================
// register addresses (word index on the register port)
`define TMR_ADDR_W          4
`define TMR_DATA_W          16
`define TMR_ADDR_CTRL       4'h0
`define TMR_ADDR_COUNT      4'h1
`define TMR_ADDR_RELOAD     4'h2
`define TMR_ADDR_PWM        4'h3
`define TMR_ADDR_CAPTURE    4'h4
`define TMR_ADDR_STATUS     4'h5

// ============================================================
// control register fields
`define TMR_CTRL_EN         0
`define TMR_CTRL_MODE_LO    1
`define TMR_CTRL_MODE_HI    3
`define TMR_CTRL_POL        4
`define TMR_CTRL_PRE_LO     5
`define TMR_CTRL_PRE_HI     7
`define TMR_CTRL_OUTEN      8
`define TMR_CTRL_W          9

// ============================================================
// status register fields
`define TMR_STAT_IN         0
`define TMR_STAT_OUT        1
`define TMR_STAT_EN         2

// ============================================================
// operating modes
`define TMR_MODE_ONESHOT    3'h0
`define TMR_MODE_CONT       3'h1
`define TMR_MODE_COUNTER    3'h2
`define TMR_MODE_PWM        3'h3
`define TMR_MODE_CAPTURE    3'h4
`define TMR_MODE_COMPARE    3'h5
`define TMR_MODE_GATED      3'h6

// ============================================================
// reset values and count constants
`define TMR_CTRL_RST        9'h000
`define TMR_COUNT_RST       16'h0001
`define TMR_RELOAD_RST      16'hFFFF
`define TMR_WORD_ZERO       16'h0000
`define TMR_COUNT_RESTART   16'h0001
`define TMR_COUNT_STEP      16'h0001
`define TMR_PRE_W           3
`define TMR_MODE_W          3
`define TMR_PRE_CNT_W       7
`define TMR_PRE_CNT_RST     7'h00
`define TMR_PRE_ONE         7'h01

`endif

// >>> timer_pin_model.sv
// model of the external source driving the timer input pin
`timescale 1ns/1ps
module timer_pin_model (
    input  wire clk_sys,
    input  wire level_cmd,
    output reg  timer_in
);
    // pin follows the commanded level just after each edge, so every level lasts a cycle
    initial timer_in = 1'b0;
    always @(posedge clk_sys) begin
        timer_in <= level_cmd;
    end
endmodule

// >>> timer_prescaler.v
// prescaler giving one tick per divided system clock period
`include "timer_defines.vh"
`timescale 1ns/1ps

module timer_prescaler (
    input  wire                        clk_sys,
    input  wire                        rst_n,
    input  wire                        run,
    input  wire [`TMR_PRE_W-1:0]       prescale_sel,
    output wire                        tick
);

    reg  [`TMR_PRE_CNT_W-1:0] div_count;
    wire [`TMR_PRE_CNT_W-1:0] div_last;

    // terminal value is two to the power of the select, minus one
    assign div_last = (`TMR_PRE_ONE << prescale_sel) - `TMR_PRE_ONE;
    assign tick     = run && (div_count == div_last);

    // ============================================================
    // divider counter, held clear while the timer is stopped
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_count <= `TMR_PRE_CNT_RST;
        end else if (!run || tick) begin
            div_count <= `TMR_PRE_CNT_RST;
        end else begin
            div_count <= div_count + `TMR_PRE_ONE;
        end
    end

endmodule
